// *** src/fec_flash_erase_controller.sv ***
// Erase sequencer for the on-chip flash with register port, interrupt and bypass.
`timescale 1ns/1ps
`default_nettype none
module fec_flash_erase_controller #(
  parameter int ERASE_CYCLES = fec_pkg::ERASE_CYCLES_DEF
) (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Register port.
  input wire fec_pkg::fec_bus_t bus_in,
  input wire logic debug_in,
  output logic [fec_pkg::DATA_W-1:0] rdata_out,
  // Processor hold and interrupt.
  output logic cpu_stall_out,
  output logic irq_out,
  // Bypass pins from the external programmer.
  input wire fec_pkg::fec_flash_t pin_flash_in,
  // Flash array control.
  output fec_pkg::fec_flash_t flash_out,
  output logic [fec_pkg::DATA_W-1:0] flash_fill_out
);
  import fec_pkg::*;

  fec_state_t state;
  fec_state_t next_state;
  logic [DATA_W-1:0] page_sel;
  logic [DATA_W-1:0] prot;
  logic bypass;
  logic mass_op;
  logic [31:0] count;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  fec_flash_t pin_s1;
  fec_flash_t pin_s2;
  logic ctrl_wr;
  logic page_ok;
  logic start_page;
  logic start_mass;
  logic done;
  logic refused;

  assign ctrl_wr = bus_in.wr && bus_in.addr == REG_CTRL;
  // Each protect bit covers one eighth of the page range.
  assign page_ok = !prot[page_sel[DATA_W-1:DATA_W-3]];
  assign start_page = ctrl_wr && bus_in.wdata == CMD_PAGE_ERASE && page_ok &&
                      (state == FEC_UNLOCKED || state == FEC_MASS_EN);
  assign start_mass = ctrl_wr && bus_in.wdata == CMD_MASS_ERASE && state == FEC_MASS_EN &&
                      debug_in;
  assign done = state == FEC_BUSY && count == 32'(ERASE_CYCLES - 1);
  // Any control write outside FEC_BUSY whose next state is FEC_LOCKED is refused.
  assign refused = ctrl_wr && !start_page && !start_mass && next_state == FEC_LOCKED &&
                   state != FEC_BUSY;

  always_comb begin
    next_state = state;
    case (state)
      FEC_LOCKED: begin
        if (ctrl_wr && bus_in.wdata == CMD_UNLOCK1) begin
          next_state = FEC_UNLK1;
        end
      end
      FEC_UNLK1: begin
        if (ctrl_wr) begin
          next_state = bus_in.wdata == CMD_UNLOCK2 ? FEC_UNLOCKED : FEC_LOCKED;
        end
      end
      FEC_UNLOCKED, FEC_MASS_EN: begin
        if (start_page || start_mass) begin
          next_state = FEC_BUSY;
        end else if (ctrl_wr && bus_in.wdata == CMD_MASS_ENABLE && debug_in) begin
          next_state = FEC_MASS_EN;
        end else if (ctrl_wr) begin
          next_state = FEC_LOCKED;
        end
      end
      FEC_BUSY: begin
        if (done) begin
          next_state = FEC_LOCKED;
        end
      end
      default: begin
        next_state = FEC_LOCKED;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= FEC_LOCKED;
    end else begin
      state <= next_state;
    end
  end

  // Writes to the page register are ignored mid-erase so the target cannot move.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      page_sel <= PAGE_RESET;
      prot <= PROT_RESET;
      bypass <= 1'b0;
    end else if (bus_in.wr && state != FEC_BUSY) begin
      if (bus_in.addr == REG_PAGE) begin
        page_sel <= bus_in.wdata;
      end
      if (bus_in.addr == REG_PROT) begin
        prot <= bus_in.wdata;
      end
      if (bus_in.addr == REG_BYPASS) begin
        bypass <= bus_in.wdata[0];
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= 32'h0000_0000;
      mass_op <= 1'b0;
    end else if (start_page || start_mass) begin
      count <= 32'h0000_0000;
      mass_op <= start_mass;
    end else if (state == FEC_BUSY) begin
      count <= count + 32'h0000_0001;
    end
  end

  // Pins cross into this clock through two flops before use.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= pin_flash_in;
      pin_s2 <= pin_s1;
    end
  end

  // Bypass hands the array to the pins; a pin page erase still works there.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flash_out <= '0;
      flash_fill_out <= ERASED_BYTE;
    end else begin
      flash_fill_out <= ERASED_BYTE;
      if (bypass) begin
        flash_out <= pin_s2;
      end else begin
        flash_out.erase <= next_state == FEC_BUSY;
        flash_out.mass <= next_state == FEC_BUSY && (start_mass || (mass_op && !start_page));
        flash_out.page <= page_sel;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cpu_stall_out <= 1'b0;
    end else begin
      cpu_stall_out <= next_state == FEC_BUSY;
    end
  end

  // Set wins over the read clear so a completion in the read cycle is kept.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      if (bus_in.wr && bus_in.addr == REG_IRQ_MASK) begin
        irq_mask <= bus_in.wdata[IRQ_W-1:0];
      end
      irq_stat <= (bus_in.rd && bus_in.addr == REG_IRQ_STAT ? '0 : irq_stat) |
                  {refused, done};
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((bus_in.rd && bus_in.addr == REG_IRQ_STAT ? '0 : irq_stat) |
                    {refused, done}) & irq_mask);
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= '0;
      if (bus_in.rd) begin
        case (bus_in.addr)
          REG_STATUS: begin
            rdata_out[ST_LOCKED_BIT] <= state == FEC_LOCKED || state == FEC_UNLK1;
            rdata_out[ST_UNLOCKED_BIT] <= state == FEC_UNLOCKED || state == FEC_MASS_EN;
            rdata_out[ST_MASS_EN_BIT] <= state == FEC_MASS_EN;
            rdata_out[ST_BUSY_BIT] <= state == FEC_BUSY;
            rdata_out[ST_PAGE_BIT] <= state == FEC_BUSY && !mass_op;
            rdata_out[ST_MASS_BIT] <= state == FEC_BUSY && mass_op;
          end
          REG_PAGE: rdata_out <= page_sel;
          REG_PROT: rdata_out <= prot;
          REG_IRQ_STAT: rdata_out <= DATA_W'(irq_stat);
          REG_IRQ_MASK: rdata_out <= DATA_W'(irq_mask);
          REG_BYPASS: rdata_out <= DATA_W'(bypass);
          default: rdata_out <= '0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** src/fec_pkg.sv ***
// Package with constants and types for the flash erase controller.
package fec_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] REG_PAGE = 4'h2;
  localparam logic [ADDR_W-1:0] REG_PROT = 4'h3;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h5;
  localparam logic [ADDR_W-1:0] REG_BYPASS = 4'h6;
  localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 8'h73;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 8'h8c;
  localparam logic [DATA_W-1:0] CMD_PAGE_ERASE = 8'h95;
  localparam logic [DATA_W-1:0] CMD_MASS_ENABLE = 8'h5a;
  localparam logic [DATA_W-1:0] CMD_MASS_ERASE = 8'h63;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
  localparam int PAGE_BYTES = 512;
  localparam int ST_LOCKED_BIT = 0;
  localparam int ST_UNLOCKED_BIT = 1;
  localparam int ST_MASS_EN_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_PAGE_BIT = 4;
  localparam int ST_MASS_BIT = 5;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_REFUSED_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int ERASE_CYCLES_DEF = 4000;
  localparam logic [DATA_W-1:0] PAGE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PROT_RESET = 8'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } fec_bus_t;

  typedef struct packed {
    logic erase;
    logic mass;
    logic [DATA_W-1:0] page;
  } fec_flash_t;

  typedef enum logic [4:0] {
    FEC_LOCKED = 5'b00001,
    FEC_UNLK1 = 5'b00010,
    FEC_UNLOCKED = 5'b00100,
    FEC_MASS_EN = 5'b01000,
    FEC_BUSY = 5'b10000
  } fec_state_t;
endpackage

// *** verification/fec_props.sv ***
// Checker of the erase controller ports.
`timescale 1ns/1ps
`default_nettype none
module fec_props
  import fec_pkg::*;
#(
  parameter int ERASE_CYCLES = 8
) (
  // Watched ports.
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire fec_pkg::fec_bus_t bus_in,
  input wire logic debug_in,
  input wire logic [fec_pkg::DATA_W-1:0] rdata_out,
  input wire logic cpu_stall_out,
  input wire logic irq_out,
  input wire fec_pkg::fec_flash_t pin_flash_in,
  input wire fec_pkg::fec_flash_t flash_out,
  input wire logic [fec_pkg::DATA_W-1:0] flash_fill_out
);
  // The hold length is counted here because a repetition cannot take a parameter.
  int run;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) run <= 0;
    else run <= cpu_stall_out ? run + 1 : 0;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  AST_FILL: assert property (flash_fill_out == ERASED_BYTE) else $error("fill value wrong");
  AST_LEN: assert property ($fell(cpu_stall_out) |-> run == ERASE_CYCLES) else $error("hold length wrong");
  AST_HOLD: assert property (cpu_stall_out |-> flash_out.erase) else $error("stall without erase");
  AST_CMD: assert property ($rose(cpu_stall_out) |-> $past(bus_in.wr) && $past(bus_in.addr) == REG_CTRL)
    else $error("erase without command");
  AST_PAGE: assert property ($rose(cpu_stall_out) && !flash_out.mass |-> $past(bus_in.wdata) == CMD_PAGE_ERASE)
    else $error("page erase on wrong value");
  AST_MASS: assert property ($rose(cpu_stall_out) && flash_out.mass |->
    $past(bus_in.wdata) == CMD_MASS_ERASE && $past(debug_in)) else $error("mass erase not from debugger");
  AST_BUSY: assert property ($past(bus_in.rd) && $past(bus_in.addr) == REG_STATUS && $past(cpu_stall_out) &&
    cpu_stall_out |-> rdata_out[ST_BUSY_BIT]) else $error("busy not shown");
  AST_MBUSY: assert property ($past(bus_in.rd) && $past(bus_in.addr) == REG_STATUS && $past(cpu_stall_out) &&
    cpu_stall_out && flash_out.mass |-> rdata_out[ST_MASS_BIT]) else $error("mass busy not shown");
endmodule
`default_nettype wire

// *** verification/fec_flash_model.sv ***
// Flash array model that logs each erase it receives.
`timescale 1ns/1ps
`default_nettype none
module fec_flash_model
  import fec_pkg::*;
(
  // Array control in, erase log out.
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire fec_pkg::fec_flash_t flash_in,
  output logic [7:0] page_out,
  output logic [7:0] mass_out
);
  logic prev;
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev <= 1'b0;
      mass_out <= 8'h00;
      page_out <= 8'h00;
    end else begin
      prev <= flash_in.erase;
      if (flash_in.erase && !prev) begin
        page_out <= flash_in.page;
        mass_out <= mass_out + 8'(flash_in.mass);
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/test_flash_erase_controller.sv ***
// Self-checking bench of the flash erase controller.
`timescale 1ns/1ps
`default_nettype none
module test_flash_erase_controller;
  import fec_pkg::*;
  localparam int EC = 8;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic debug_in = 1'b0;
  fec_bus_t bus_in = '0;
  fec_flash_t pin_flash_in = '0;
  fec_flash_t flash_out;
  logic [7:0] rdata_out, flash_fill_out, m_page, m_mass, d, pg;
  logic cpu_stall_out, irq_out;
  logic [31:0] seed = 32'd2107;
  int n_fail = 0, checks = 0, stall_n = 0, s0;
  always #12.5 clock_in = ~clock_in;
  always @(posedge clock_in) stall_n <= stall_n + int'(cpu_stall_out);
  fec_flash_erase_controller #(.ERASE_CYCLES(EC)) DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .bus_in(bus_in),
    .debug_in(debug_in), .rdata_out(rdata_out), .cpu_stall_out(cpu_stall_out), .irq_out(irq_out),
    .pin_flash_in(pin_flash_in), .flash_out(flash_out), .flash_fill_out(flash_fill_out));
  fec_flash_model FM (.clock_in(clock_in), .rst_n_in(rst_n_in), .flash_in(flash_out), .page_out(m_page),
    .mass_out(m_mass));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] st(int b);
    return 8'h01 << b;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("fails=%0d checks=%0d", n_fail, checks);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic dbg = 1'b0);
    @(posedge clock_in);
    bus_in <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    debug_in <= dbg;
    @(posedge clock_in);
    bus_in.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock_in);
    bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_in);
    bus_in.rd <= 1'b0;
    #1 d = rdata_out;
  endtask
  // The erase end is found by polling status, as the debugger must; a stuck busy ends the run.
  task automatic poll();
    int i;
    for (i = 0; i < 40; i++) begin
      rd(REG_STATUS);
      if (d[ST_BUSY_BIT] === 1'b0) break;
    end
    if (i == 40) begin
      n_fail++;
      close_out();
    end
  endtask
  // The bench only erases and never programs, so no byte is written twice between erases
  task automatic run(input logic [7:0] v, input logic dbg, input logic go);
    logic [7:0] mm;
    s0 = stall_n;
    mm = m_mass;
    wr(REG_CTRL, CMD_UNLOCK1);
    wr(REG_CTRL, CMD_UNLOCK2);
    if (v == CMD_MASS_ERASE) wr(REG_CTRL, CMD_MASS_ENABLE, dbg);
    wr(REG_CTRL, v, dbg);
    poll();
    chk(8'(stall_n - s0), go ? 8'(EC) : 8'h00);
    chk(m_mass - mm, {7'h0, go && v == CMD_MASS_ERASE});
    if (go && v == CMD_PAGE_ERASE) chk(m_page, pg);
    rd(REG_STATUS);
    chk(d, st(ST_LOCKED_BIT));
    rd(REG_IRQ_STAT);
    if (go) chk(d, st(IRQ_DONE_BIT));
  endtask
  initial begin
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd(REG_STATUS);
    chk(d, st(ST_LOCKED_BIT));
    wr(4'hf, rnd());
    rd(4'hf);
    chk(d, 8'h00);
    wr(REG_IRQ_MASK, 8'h00);
    wr(REG_CTRL, CMD_PAGE_ERASE);
    #1 chk({7'h0, cpu_stall_out}, 8'h00);
    wr(REG_IRQ_MASK, 8'h03);
    #1 chk({7'h0, irq_out}, 8'h00);
    repeat (2) @(posedge clock_in);
    #1 chk({7'h0, irq_out}, 8'h01);
    rd(REG_IRQ_STAT);
    chk(d, st(IRQ_REFUSED_BIT));
    wr(REG_PROT, 8'h01);
    for (int i = 0; i < 4; i++) begin
      pg = (i == 0) ? rnd() & 8'h1f : rnd() | 8'h20;
      wr(REG_PAGE, pg);
      rd(REG_PAGE);
      chk(d, pg);
      run(CMD_PAGE_ERASE, 1'b0, pg[7:5] != 3'h0);
    end
    run(rnd() & 8'h0f, 1'b0, 1'b0);
    run(CMD_MASS_ERASE, 1'b0, 1'b0);
    run(CMD_MASS_ERASE, 1'b1, 1'b1);
    wr(REG_BYPASS, 8'h01);
    pg = rnd();
    pin_flash_in <= '{erase: 1'b1, mass: 1'b0, page: pg};
    repeat (6) @(posedge clock_in);
    #1 chk(flash_out.page, pg);
    chk(m_page, pg);
    close_out();
  end
endmodule
bind fec_flash_erase_controller fec_props #(.ERASE_CYCLES(ERASE_CYCLES)) u_props (.clock_in(clock_in),
  .rst_n_in(rst_n_in), .bus_in(bus_in), .debug_in(debug_in), .rdata_out(rdata_out), .cpu_stall_out(cpu_stall_out),
  .irq_out(irq_out), .pin_flash_in(pin_flash_in), .flash_out(flash_out), .flash_fill_out(flash_fill_out));
`default_nettype wire
